// ==== rtl/tmc_pkg.sv ====
/*
  Package of the timer-mode counter with auto-capture: register offsets,
  field positions, reset values and tick timing.
  Assumes a 40 MHz pclk and an APB master as the only software party.
*/
// Contract
// - Four modes exist; only timer mode behaviour is built here.
// - Counter increments once per selected source clock tick while started.
// - Counter equal to compare raises match interrupt and clears counter.
// - After the clear counting resumes from zero by itself.
// - Auto-capture enable set copies the running count to capture register.
// - Capture updates on source ticks; first value one tick after enabling.
// - Select 00 gives 128 or 244.14 us; 01 8.0 us; 10 0.5 us.
// - Compare loads at first tick after high byte write; low alone inert.
// - Processor stop mode clears start field to stop, halting counter.
package tmc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] TMC_CTRL_OFF = 8'h00;
  localparam logic [7:0] TMC_CMPL_OFF = 8'h04;
  localparam logic [7:0] TMC_CMPH_OFF = 8'h08;
  localparam logic [7:0] TMC_CAPT_OFF = 8'h0c;
  localparam logic [7:0] TMC_STAT_OFF = 8'h10;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int TMC_MODE_LSB = 0;
  localparam int TMC_CKSEL_LSB = 2;
  localparam int TMC_START_LSB = 4;
  localparam int TMC_ACAP_BIT = 6;
  localparam int TMC_TAP_BIT = 7;
  localparam logic [1:0] TMC_START_STOP = 2'h0;
  localparam logic [1:0] TMC_START_CMD = 2'h1;
  localparam logic [1:0] TMC_MODE_TIMER = 2'h0;
  localparam logic [7:0] TMC_CTRL_RST = 8'h00;
  localparam logic [15:0] TMC_CMP_RST = 16'hffff;
  // ----------------------------------------
  // Tick periods in nanoseconds and cycles
  // ----------------------------------------
  localparam int TMC_CLK_NS = 25;
  localparam real TMC_T00_NS = 128000.0;
  localparam real TMC_T00S_NS = 244140.0;
  localparam real TMC_T01_NS = 8000.0;
  localparam real TMC_T10_NS = 500.0;
  localparam int TMC_C00 = int'(TMC_T00_NS / TMC_CLK_NS);
  localparam int TMC_C00S = int'(TMC_T00S_NS / TMC_CLK_NS);
  localparam int TMC_C01 = int'(TMC_T01_NS / TMC_CLK_NS);
  localparam int TMC_C10 = int'(TMC_T10_NS / TMC_CLK_NS);
  localparam int TMC_DIV_W = 14;
endpackage : tmc_pkg

// ==== rtl/tmc_tick_if.sv ====
/*
  Interface carrying the source tick from the divider to the timer core.
  Assumes both ends share pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface tmc_tick_if;
  logic [1:0] sel;
  logic tap;
  logic slow;
  logic tick;
  modport div (input sel, input tap, input slow, output tick);
  modport core (output sel, output tap, output slow, input tick);
endinterface : tmc_tick_if
`default_nettype wire

// ==== rtl/tmc_divider.sv ====
/*
  Source clock divider: one-cycle tick per selected source period.
  Assumes pclk at 40 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_divider
  import tmc_pkg::*;
#(
  parameter int C00 = TMC_C00,
  parameter int C00S = TMC_C00S,
  parameter int C01 = TMC_C01,
  parameter int C10 = TMC_C10
) (
  input wire logic pclk,
  input wire logic presetn,
  tmc_tick_if.div tk
);
  typedef struct packed {
    logic [TMC_DIV_W-1:0] cnt;
    logic tick;
  } tmc_div_t;
  tmc_div_t s_q;
  tmc_div_t s_d;
  logic [TMC_DIV_W-1:0] lim;
  // ----------------------------------------
  // Period select
  // ----------------------------------------
  always_comb begin
    case (tk.sel)
      2'h0: lim = (tk.tap || tk.slow) ? TMC_DIV_W'(C00S - 1) : TMC_DIV_W'(C00 - 1);
      2'h1: lim = TMC_DIV_W'(C01 - 1);
      2'h2: lim = TMC_DIV_W'(C10 - 1);
      default: lim = '1;
    endcase
  end
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= lim) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tk.tick = s_q.tick;
endmodule : tmc_divider
`default_nettype wire

// ==== rtl/tmc_timer.sv ====
/*
  Timer-mode 16-bit up-counter with compare match and auto-capture,
  registers over APB. Assumes an APB master on pclk; stop_mode_entry is a
  level from the same clock domain.
*/
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int C00 = TMC_C00,
  parameter int C00S = TMC_C00S
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_mode,
  input wire logic stop_mode_entry,
  output logic match_interrupt
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmp_lo;
    logic [15:0] cmp_shadow;
    logic cmp_pend;
    logic [15:0] cmp;
    logic [15:0] cnt;
    logic [15:0] capt;
    logic irq;
    logic [31:0] rdata;
  } tmc_state_t;
  tmc_state_t s_q;
  tmc_state_t s_d;
  tmc_tick_if tk ();
  logic wr;
  logic rd;
  logic started;
  logic mapped;
  tmc_divider #(.C00(C00), .C00S(C00S)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr = psel && penable && pwrite;
  // Read decoded in setup phase, data registered for the access phase
  assign rd = psel && !penable && !pwrite;
  assign mapped = paddr inside {TMC_CTRL_OFF, TMC_CMPL_OFF, TMC_CMPH_OFF, TMC_CAPT_OFF, TMC_STAT_OFF};
  assign started = s_q.ctrl[TMC_START_LSB +: 2] == TMC_START_CMD &&
                   s_q.ctrl[TMC_MODE_LSB +: 2] == TMC_MODE_TIMER;
  assign tk.sel = s_q.ctrl[TMC_CKSEL_LSB +: 2];
  assign tk.tap = s_q.ctrl[TMC_TAP_BIT];
  assign tk.slow = slow_mode;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    if (wr && paddr == TMC_CTRL_OFF) begin
      s_d.ctrl = pwdata[7:0];
    end
    if (wr && paddr == TMC_CMPL_OFF) begin
      s_d.cmp_lo = pwdata[7:0];
    end
    if (wr && paddr == TMC_CMPH_OFF) begin
      s_d.cmp_shadow = {pwdata[7:0], s_q.cmp_lo};
      s_d.cmp_pend = 1'b1;
    end
    if (tk.tick && s_q.cmp_pend) begin
      s_d.cmp = s_q.cmp_shadow;
      s_d.cmp_pend = wr && paddr == TMC_CMPH_OFF;
    end
    if (!started) begin
      s_d.cnt = '0;
    end else if (tk.tick) begin
      if (s_q.cnt == s_q.cmp) begin
        s_d.cnt = '0;
        s_d.irq = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (s_q.ctrl[TMC_ACAP_BIT]) begin
        s_d.capt = s_q.cnt;
      end
    end
    if (stop_mode_entry) begin
      s_d.ctrl[TMC_START_LSB +: 2] = TMC_START_STOP;
    end
    s_d.rdata = '0;
    if (rd) begin
      case (paddr)
        TMC_CTRL_OFF: s_d.rdata = {24'h000000, s_q.ctrl};
        TMC_CMPL_OFF: s_d.rdata = {24'h000000, s_q.cmp[7:0]};
        TMC_CMPH_OFF: s_d.rdata = {24'h000000, s_q.cmp[15:8]};
        TMC_CAPT_OFF: s_d.rdata = {16'h0000, s_q.capt};
        TMC_STAT_OFF: s_d.rdata = {16'h0000, s_q.cnt};
        default: s_d.rdata = '0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{ctrl: TMC_CTRL_RST, cmp_lo: 8'h00, cmp_shadow: TMC_CMP_RST, cmp_pend: 1'b0,
               cmp: TMC_CMP_RST, cnt: 16'h0000, capt: 16'h0000, irq: 1'b0, rdata: 32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;
  assign match_interrupt = s_q.irq;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence tmc_match_s;
    started && tk.tick && s_q.cnt == s_q.cmp && !stop_mode_entry;
  endsequence
  match_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    tmc_match_s |=> match_interrupt && s_q.cnt == 16'h0000)
    else $error("match did not clear counter");
  count_steps_a: assert property (@(posedge pclk) disable iff (!presetn)
    started && tk.tick && s_q.cnt != s_q.cmp && !stop_mode_entry |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("counter did not step");
  count_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    started && !tk.tick && !stop_mode_entry |=> $stable(s_q.cnt))
    else $error("counter moved without tick");
  stopped_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !started |=> s_q.cnt == 16'h0000 && !match_interrupt)
    else $error("stopped counter active");
  stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode_entry |=> s_q.ctrl[TMC_START_LSB +: 2] == TMC_START_STOP)
    else $error("stop mode did not clear start");
  capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    started && tk.tick && s_q.ctrl[TMC_ACAP_BIT] |=> s_q.capt == $past(s_q.cnt))
    else $error("capture missed");
  capture_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tk.tick |=> $stable(s_q.capt))
    else $error("capture off tick");
  cmp_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tk.tick |=> $stable(s_q.cmp))
    else $error("compare loaded off tick");
  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    started && tk.tick && s_q.cnt == 16'h0000 && s_q.cmp != 16'h0000 |=> s_q.cnt == 16'h0001)
    else $error("no restart after match");
endmodule : tmc_timer
`default_nettype wire

// ==== tb/tmc_timer_tb.sv ====
/*
  Self-checking bench of the timer-mode counter: APB register access,
  match period per clock select, compare loading, capture and stop.
  Assumes tmc_timer with shortened select-00 counts (8 and 12 cycles).
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_tb;
  import tmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, slow_mode, stop_mode_entry;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, match_interrupt, er;
  int err_count, compares, n;
  logic [7:0] ra [6] = '{TMC_CTRL_OFF, TMC_CMPL_OFF, TMC_CMPH_OFF, TMC_CAPT_OFF, TMC_STAT_OFF, 8'h14};
  logic [31:0] rv [6] = '{32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0};
  logic re [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] cv [4] = '{8'h00, 8'h80, 8'h00, 8'h04};
  logic sv [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int pv [4] = '{48, 72, 72, 1920};
  logic [7:0] xc [2] = '{8'h0c, 8'h01};

  tmc_timer #(.C00(8), .C00S(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_mode(slow_mode), .stop_mode_entry(stop_mode_entry), .match_interrupt(match_interrupt));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_of_test;
    $display("Checks %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      err_count++;
      end_of_test();
    end
  endtask

  task wait_irq;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (match_interrupt !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      err_count++;
      end_of_test();
    end
  endtask

  task per(input int e);
    wait_irq();
    wait_irq();
    chk("period", e, n);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow_mode = 1'b0;
    stop_mode_entry = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("read", rv[i], rd);
      chk("slverr", {31'h0, re[i]}, {31'h0, er});
    end
    apb(1'b1, TMC_CMPL_OFF, 32'h05);
    apb(1'b1, TMC_CMPH_OFF, 32'h00);
    for (int i = 0; i < 4; i++) begin
      slow_mode <= sv[i];
      apb(1'b1, TMC_CTRL_OFF, {24'h0, cv[i]});
      apb(1'b1, TMC_CTRL_OFF, {24'h0, cv[i] | 8'h10});
      per(pv[i]);
    end
    apb(1'b1, TMC_CTRL_OFF, 32'h08);
    apb(1'b1, TMC_CMPL_OFF, 32'h03);
    apb(1'b1, TMC_CMPH_OFF, 32'h00);
    apb(1'b1, TMC_CTRL_OFF, 32'h18);
    per(80);
    apb(1'b1, TMC_CMPL_OFF, 32'h05);
    per(80);
    apb(1'b1, TMC_CMPH_OFF, 32'h00);
    per(120);
    apb(1'b1, TMC_CMPL_OFF, 32'h03);
    apb(1'b1, TMC_CMPH_OFF, 32'h00);
    apb(1'b1, TMC_CTRL_OFF, 32'h58);
    wait_irq();
    wait_irq();
    repeat (25) @(posedge pclk);
    apb(1'b0, TMC_STAT_OFF, 32'h0);
    chk("count", 32'h1, rd);
    apb(1'b0, TMC_CAPT_OFF, 32'h0);
    chk("capture", 32'h0, rd);
    apb(1'b1, TMC_CTRL_OFF, 32'h08);
    apb(1'b0, TMC_STAT_OFF, 32'h0);
    chk("stopped count", 32'h0, rd);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (match_interrupt === 1'b1) n++;
    end
    chk("stopped irq", 32'h0, n);
    apb(1'b1, TMC_CTRL_OFF, 32'h18);
    wait_irq();
    stop_mode_entry <= 1'b1;
    @(posedge pclk);
    stop_mode_entry <= 1'b0;
    apb(1'b0, TMC_CTRL_OFF, 32'h0);
    chk("start field", 32'h0, rd & 32'h30);
    apb(1'b0, TMC_STAT_OFF, 32'h0);
    chk("halted count", 32'h0, rd);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, TMC_CTRL_OFF, 32'h0c);
      apb(1'b1, TMC_CTRL_OFF, {24'h0, xc[i]});
      apb(1'b1, TMC_CTRL_OFF, {24'h0, xc[i] | 8'h10});
      repeat (100) @(posedge pclk);
      apb(1'b0, TMC_STAT_OFF, 32'h0);
      chk("idle count", 32'h0, rd);
    end
    end_of_test();
  end
endmodule // tmc_timer_tb
`default_nettype wire
